// File: rtl/sdli_pkg.sv
// Package of constants for the serial converter load interface
package sdli_pkg;
    // Word width and the frame length in serial clock falling edges
    localparam int CODE_W = 8;
    localparam int FRAME_EDGES = 8;
    localparam logic [3:0] FRAME_EDGES_C = 4'h8;
    // Values after reset
    localparam logic [7:0] CODE_RESET = 8'h00;
    localparam logic [3:0] COUNT_RESET = 4'h0;
    // Pin levels at rest, bit 3 down: load, select, data, serial clock
    localparam logic [3:0] PIN_RESET = 4'hd;
    // Full scale divisor of the straight binary code
    localparam int FULL_SCALE = 256;
    // Buffer depth between the shifter and the latch
    localparam int BUF_DEPTH = 2;
endpackage

// File: rtl/sdli_word_if.sv
// Valid/ready word carrier between shifter and buffer
`timescale 1ns/10ps
interface sdli_word_if #(
    parameter int W = 8
);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface

// File: rtl/sdli_buf.sv
// Two-entry word buffer with valid and ready on both sides
`timescale 1ns/10ps
module sdli_buf #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Fill side
    sdli_word_if.dst wr,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] mem [0:1];
    logic wp;
    logic rp;
    logic [1:0] cnt;
    logic push;
    logic pop;

    assign wr.ready = (cnt != 2'h2);
    assign out_valid = (cnt != 2'h0);
    assign out_data = mem[rp];
    assign push = wr.valid && wr.ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mem[0] <= sdli_pkg::CODE_RESET;
            mem[1] <= sdli_pkg::CODE_RESET;
        end else if (push) begin
            mem[wp] <= wr.data;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wp <= 1'b0;
            rp <= 1'b0;
            cnt <= 2'h0;
        end else begin
            if (push) begin
                wp <= ~wp;
            end
            if (pop) begin
                rp <= ~rp;
            end
            cnt <= cnt + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// File: rtl/sdli_top.sv
// Serial input port and output latch control of an 8-bit converter
`timescale 1ns/10ps
module sdli_top #(
    parameter int W = sdli_pkg::CODE_W
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Serial pins from the controller
    input wire logic serial_clk,
    input wire logic serial_data_in,
    input wire logic frame_sel_n,
    input wire logic load_output_n,
    // Converter latch
    output logic [W-1:0] dac_code,
    output logic dac_update,
    // Word received, not yet loaded
    output logic word_pending
);
    // ==========================================
    // Pin synchronisers
    // Pin vector order: serial clock, data, frame select, load
    localparam int N_PINS = 4;

    logic [N_PINS-1:0] pin_raw;
    logic [N_PINS-1:0] pin_sync;
    logic sclk_sync;
    logic serial_data_in_sync;
    logic fsel_sync;
    logic load_sync;

    assign pin_raw = {load_output_n, frame_sel_n,
        serial_data_in, serial_clk};

    // Two flops per pin; only the second stage is read by any logic,
    // so a metastable first stage never fans out
    for (genvar gi = 0; gi < N_PINS; gi++) begin : g_sync
        logic meta;
        logic sync;

        always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
                meta <= sdli_pkg::PIN_RESET[gi];
                sync <= sdli_pkg::PIN_RESET[gi];
            end else begin
                meta <= pin_raw[gi];
                sync <= meta;
            end
        end

        assign pin_sync[gi] = sync;
    end

    assign sclk_sync = pin_sync[0];
    assign serial_data_in_sync = pin_sync[1];
    assign fsel_sync = pin_sync[2];
    assign load_sync = pin_sync[3];

    // ==========================================
    // Edge and frame decode
    // Each serial clock phase must last three or more ref_clk cycles
    logic sclk_d;
    logic load_d;
    logic sclk_fall;
    logic load_fall;
    logic in_frame;
    logic load_low;

    // Delayed copies start at the rest level of their pins, so leaving
    // reset never looks like a serial clock or load falling edge
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sclk_d <= sdli_pkg::PIN_RESET[0];
        end else begin
            sclk_d <= sclk_sync;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            load_d <= sdli_pkg::PIN_RESET[3];
        end else begin
            load_d <= load_sync;
        end
    end

    assign in_frame = !fsel_sync;
    assign sclk_fall = sclk_d && !sclk_sync;
    assign load_fall = load_d && !load_sync;
    assign load_low = !load_sync;

    // ==========================================
    // Shifter
    typedef enum logic [1:0] {
        SDLI_IDLE = 2'b00,
        SDLI_SHIFT = 2'b01,
        SDLI_DONE = 2'b10
    } sdli_state_t;

    sdli_state_t state;
    sdli_state_t next_state;
    logic [W-1:0] shift;
    logic [3:0] bit_cnt;
    logic word_done;

    sdli_word_if #(.W(W)) word_bus ();

    // Extra falls after the eighth are ignored until select rises
    always_comb begin
        next_state = state;
        case (state)
            SDLI_IDLE: begin
                if (in_frame) begin
                    next_state = SDLI_SHIFT;
                end
            end
            SDLI_SHIFT: begin
                if (!in_frame) begin
                    next_state = SDLI_IDLE;
                end else if (word_done) begin
                    next_state = SDLI_DONE;
                end
            end
            SDLI_DONE: begin
                if (!in_frame) begin
                    next_state = SDLI_IDLE;
                end
            end
            default: begin
                next_state = SDLI_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state <= SDLI_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign word_done = (state == SDLI_SHIFT) && in_frame && sclk_fall &&
        (bit_cnt == sdli_pkg::FRAME_EDGES_C - 4'h1);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            shift <= sdli_pkg::CODE_RESET;
        end else if ((state == SDLI_SHIFT) && in_frame && sclk_fall) begin
            shift <= {shift[W-2:0], serial_data_in_sync};
        end
    end

    // Count falls; a cut frame restarts from zero
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            bit_cnt <= sdli_pkg::COUNT_RESET;
        end else if (state != SDLI_SHIFT) begin
            bit_cnt <= sdli_pkg::COUNT_RESET;
        end else if (in_frame && sclk_fall) begin
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    assign word_bus.valid = word_done;
    assign word_bus.data = {shift[W-2:0], serial_data_in_sync};

    // ==========================================
    // Word buffer and converter latch
    logic buf_valid;
    logic buf_ready;
    logic [W-1:0] buf_data;

    sdli_buf #(.W(W)) u_buf (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .wr(word_bus.dst),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_data)
    );

    logic pop_word;

    // Load fall or held-low auto update
    // Held low, the load drains one buffered word per cycle; a word that
    // completes while both entries are full is dropped
    assign buf_ready = load_fall || load_low;
    assign word_pending = buf_valid;
    assign pop_word = buf_valid && buf_ready;

    // Code held as unsigned binary, code/256 of full scale
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dac_code <= sdli_pkg::CODE_RESET;
        end else if (pop_word) begin
            dac_code <= buf_data;
        end
    end

    // One-cycle strobe for each write of the latch
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dac_update <= 1'b0;
        end else begin
            dac_update <= pop_word;
        end
    end
endmodule

// File: tb/sdli_top_props.sv
// Port checks for the converter load interface
`timescale 1ns/10ps
module sdli_top_props #(
    parameter int W = 8
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic serial_clk,
    input wire logic serial_data_in,
    input wire logic frame_sel_n,
    input wire logic load_output_n,
    input wire logic [W-1:0] dac_code,
    input wire logic dac_update,
    input wire logic word_pending
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    chk_code_held: assert property (
        !dac_update |-> $stable(dac_code)) else $error("latch moved");
    chk_reset_zero: assert property (
        $rose(resetn) |-> dac_code == '0 && !word_pending)
        else $error("not zero");
    chk_load_cause: assert property (
        dac_update |-> !$past(load_output_n, 2) || !$past(load_output_n, 4))
        else $error("update without load");
    chk_auto_drain: assert property (
        not ((word_pending && !load_output_n) [*8])) else $error("stuck");
    chk_word_on_fall: assert property (
        $rose(word_pending) |-> !$past(serial_clk)) else $error("no fall");
    chk_word_in_frame: assert property (
        $rose(word_pending) |-> !frame_sel_n) else $error("no frame");
    chk_pend_clears: assert property (
        $fell(word_pending) |-> dac_update || $past(dac_update))
        else $error("word lost");
    chk_update_source: assert property (
        dac_update |-> $past(word_pending)) else $error("no word");
    cover property (dac_update && !load_output_n);
    cover property ($rose(word_pending));
    cover property (dac_update && word_pending);
endmodule

// File: tb/sdli_host_model.sv
// Serial controller model driving frame, clock and data pins
`timescale 1ns/10ps
module sdli_host_model (
    input wire logic ref_clk,
    output logic serial_clk,
    output logic serial_data_in,
    output logic frame_sel_n
);
    initial begin
        serial_clk = 1'b1;
        serial_data_in = 1'b0;
        frame_sel_n = 1'b1;
    end
    task automatic half();
        repeat (20) @(posedge ref_clk);
    endtask
    // frame of n falls, MSB first
    task automatic send(input logic [7:0] w, input int n);
        @(posedge ref_clk);
        frame_sel_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            serial_data_in <= w[7 - (i % 8)];
            half();
            serial_clk <= 1'b0;
            half();
            serial_clk <= 1'b1;
        end
        half();
        // Released line shows the inverse so stale data cannot pass
        serial_data_in <= ~serial_data_in;
        frame_sel_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        // Hand back between edges so outputs are settled when looked at
        @(negedge ref_clk);
    endtask
endmodule

// File: tb/sdli_top_tb.sv
// Self-checking bench for the converter load interface
`timescale 1ns/10ps
module sdli_top_tb;
    logic ref_clk, resetn, load_output_n, sck, sdi, fsn, upd, pend;
    logic [7:0] code;
    int n_mismatch = 0, samples_checked = 0;
    int n_upd = 0;
    sdli_host_model sdli_host_model_inst (.ref_clk(ref_clk),
        .serial_clk(sck), .serial_data_in(sdi), .frame_sel_n(fsn));
    sdli_top sdli_top_inst (.ref_clk(ref_clk), .resetn(resetn),
        .serial_clk(sck), .serial_data_in(sdi), .frame_sel_n(fsn),
        .load_output_n(load_output_n), .dac_code(code),
        .dac_update(upd), .word_pending(pend));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // Latch strobes counted between edges, away from their launch
    always @(negedge ref_clk) begin
        if (upd === 1'b1) begin
            n_upd++;
        end
    end
    task automatic chk(input string s, input logic [7:0] e, g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic load(input int n);
        @(posedge ref_clk);
        load_output_n <= 1'b0;
        repeat (n) @(posedge ref_clk);
        load_output_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic t_pulse();
        int u0;
        sdli_host_model_inst.send(8'ha5, 8);
        chk("pend", 8'h01, pend);
        chk("code", 8'h00, code);
        u0 = n_upd;
        load(6);
        chk("code", 8'ha5, code);
        chk("pend", 8'h00, pend);
        chk("upd", 8'h01, 8'(n_upd - u0));
    endtask
    task automatic t_frames();
        sdli_host_model_inst.send(8'h3c, 5);
        chk("pend", 8'h00, pend);
        sdli_host_model_inst.send(8'hc3, 9);
        load(6);
        chk("code", 8'hc3, code);
    endtask
    task automatic t_auto();
        logic [7:0] tbl [3] = '{8'h81, 8'hff, 8'h00};
        int u0;
        @(posedge ref_clk);
        load_output_n <= 1'b0;
        foreach (tbl[i]) begin
            u0 = n_upd;
            sdli_host_model_inst.send(tbl[i], 8);
            chk("auto", tbl[i], code);
            chk("aupd", 8'h01, 8'(n_upd - u0));
        end
        @(posedge ref_clk);
        load_output_n <= 1'b1;
    endtask
    task automatic t_fill();
        int u0;
        sdli_host_model_inst.send(8'h11, 8);
        sdli_host_model_inst.send(8'h22, 8);
        sdli_host_model_inst.send(8'h33, 8);
        u0 = n_upd;
        load(12);
        chk("drain", 8'h22, code);
        chk("pend", 8'h00, pend);
        chk("dupd", 8'h02, 8'(n_upd - u0));
    endtask
    initial begin
        resetn = 1'b0;
        load_output_n = 1'b1;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("rst", 8'h00, code);
        t_pulse();
        t_frames();
        t_auto();
        t_fill();
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        end_of_test();
    end
endmodule
bind sdli_top sdli_top_props #(.W(W)) sdli_top_props_inst (.*);
